//--- els_cfg.svh
// Purpose: Offsets, bit positions, reset values and counts of the unit
// Assumes: Byte-wide registers at their printed addresses
// Notes: Definitions only
`ifndef ELS_CFG_SVH
`define ELS_CFG_SVH
`define ELS_OFF_BREAK 16'hfe00
`define ELS_OFF_CAUSE 16'hfe01
`define ELS_OFF_BFLAG 16'hfe03
`define ELS_OFF_IRQA 16'hfe04
`define ELS_OFF_IRQB 16'hfe05
`define ELS_OFF_IRQC 16'hfe06
`define ELS_BIT_BEXIT 1
`define ELS_BIT_BREAK_CLEAR_ENABLE 7
`define ELS_BIT_POR 7
`define ELS_BIT_PIN 6
`define ELS_BIT_WDOG 5
`define ELS_BIT_BADOP 4
`define ELS_BIT_BADFETCH 3
`define ELS_BIT_MONITOR 2
`define ELS_BIT_LOWV 1
`define ELS_RST_CAUSE 8'h80
`define ELS_RST_BREAK 8'h00
`define ELS_RST_BFLAG 8'h00
`define ELS_STOP_LONG 4096
`define ELS_STOP_SHORT 32
`define ELS_VEC_NONE 5'h00
`define ELS_VEC_SOFT 5'h1f
`endif

//--- els_cpu_model.sv
// Purpose: Behavioural CPU core facing the unit's exception side
// Assumes: One instruction retires every eighth clocked cycle
// Notes: Acknowledge delay selectable, prompt or slow
`timescale 1ns/1ps
module els_cpu_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic intReq,
    input wire logic cpuClockEn,
    input wire logic slowAck,
    output logic instrDone,
    output logic intAck
);
    logic [2:0] stepQ;
    logic [3:0] ackWaitQ;
    wire logic ackNow = intReq && !intAck && cpuClockEn && ackWaitQ == (slowAck ? 4'h9 : 4'h1);
    // A gated CPU retires nothing; each latched vector is taken once
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            stepQ <= 3'h0;
            ackWaitQ <= 4'h0;
            instrDone <= 1'b0;
            intAck <= 1'b0;
        end
        else
        begin
            stepQ <= cpuClockEn ? stepQ + 3'h1 : stepQ;
            instrDone <= cpuClockEn && stepQ == 3'h7;
            intAck <= ackNow;
            ackWaitQ <= (intReq && !intAck && !ackNow && cpuClockEn) ? ackWaitQ + 4'h1 : 4'h0;
        end
    end
endmodule : els_cpu_model

//--- els_pkg.sv
// Purpose: Types shared by the exception and low-power unit
// Assumes: Nothing beyond the config header
// Notes: Power states of the sequencer
package els_pkg;
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_WAIT,
        PWR_STOP,
        PWR_RECOVER
    } els_pwr_type;
endpackage : els_pkg

//--- els_unit.sv
// Purpose: Exception arbitration, break handling and wait/stop sequencing
// Assumes: Requests, strobes and crystal ticks come from ref_clk logic
// Notes: Reset pin and external interrupt line level are synchronised
//
// Design decision made here: the plain strobed port.
`include "els_cfg.svh"
`timescale 1ns/1ps
module els_unit #(
    parameter int LONG_CYC = `ELS_STOP_LONG,
    parameter int SHORT_CYC = `ELS_STOP_SHORT
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic [15:0] irqReq,
    input wire logic cpuIMask,
    input wire logic instrDone,
    input wire logic intAck,
    input wire logic breakReq,
    input wire logic breakDone,
    input wire logic waitExec,
    input wire logic stopExec,
    input wire logic xtalTick,
    input wire logic shortStopRecovery,
    input wire logic watchdogDisable,
    input wire logic pinResetN,
    input wire logic watchdogReset,
    input wire logic badOpcodeReset,
    input wire logic badFetchAddr,
    input wire logic opcodeFetch,
    input wire logic monitorEntry,
    input wire logic vectorsBlank,
    input wire logic irqLinePin,
    input wire logic lowVoltageReset,
    output logic internalReset,
    output logic intReq,
    output logic [4:0] vectorId,
    output logic swiForce,
    output logic breakState,
    output logic clearIMask,
    output logic cpuClockEn,
    output logic periphClockEn,
    output logic busClockEn,
    output logic crystalClockEn,
    output logic watchdogEnable,
    output logic flagClearAllow
);
    import els_pkg::*;

    localparam logic [12:0] LongLast = 13'(LONG_CYC - 1);
    localparam logic [12:0] ShortLast = 13'(SHORT_CYC - 1);
    // Reset images held as constants so single bits can be picked
    localparam logic [7:0] BreakRst = `ELS_RST_BREAK;
    localparam logic [7:0] BflagRst = `ELS_RST_BFLAG;

    // Priority encoder, lowest source number wins
    function automatic logic [4:0] pickSource(input logic [15:0] req);
        logic [4:0] code;
        code = `ELS_VEC_NONE;
        for (int i = 15; i >= 0; i--)
        begin
            if (req[i])
            begin
                code = 5'(i + 1);
            end
        end
        return code;
    endfunction : pickSource

    els_pwr_type state_q, state_d;
    logic [12:0] count_q, count_d;
    logic shortSel_q, shortSel_d;
    logic pinMeta_q, pinSync_q;
    logic lineMeta_q, lineSync_q;
    logic [7:0] cause_q, cause_d;
    logic bexit_q, bexit_d;
    logic break_clear_enable_q, break_clear_enable_d;
    logic [7:0] rdata_q, rdata_d;
    logic latched_q, latched_d;
    logic [4:0] vector_q, vector_d;
    logic swi_q, swi_d;
    logic brkState_q, brkState_d;
    logic brkPend_q, brkPend_d;
    logic wakeArb_q, wakeArb_d;
    logic clrMask_q, clrMask_d;
    logic intRst_q;

    // Address decode
    wire selBreak = regAddr == `ELS_OFF_BREAK;
    wire selCause = regAddr == `ELS_OFF_CAUSE;
    wire selBflag = regAddr == `ELS_OFF_BFLAG;
    wire selIrqA = regAddr == `ELS_OFF_IRQA;
    wire selIrqB = regAddr == `ELS_OFF_IRQB;
    wire selIrqC = regAddr == `ELS_OFF_IRQC;

    // Live request views, never stored so reads cannot disturb them
    wire [7:0] irqViewA = {irqReq[0], irqReq[1], irqReq[2], irqReq[3], irqReq[4], irqReq[5], 2'b00};
    wire [7:0] irqViewB = {irqReq[13:6]};
    wire [7:0] irqViewC = {6'b00_0000, irqReq[15:14]};

    // Reset sources, each qualified on its own
    wire pinHit = ~pinSync_q;
    wire fetchHit = badFetchAddr & opcodeFetch;
    wire monHit = monitorEntry & vectorsBlank & lineSync_q;
    wire anyReset = pinHit | watchdogReset | badOpcodeReset | fetchHit | monHit | lowVoltageReset;

    // Cause flags of this reset event, all set together
    logic [7:0] causeSet;
    always_comb
    begin
        causeSet = 8'h00;
        causeSet[`ELS_BIT_PIN] = pinHit;
        causeSet[`ELS_BIT_WDOG] = watchdogReset;
        causeSet[`ELS_BIT_BADOP] = badOpcodeReset;
        causeSet[`ELS_BIT_BADFETCH] = fetchHit;
        causeSet[`ELS_BIT_MONITOR] = monHit;
        causeSet[`ELS_BIT_LOWV] = lowVoltageReset;
    end

    // Register strobes
    wire readCause = regRead & selCause;
    wire writeBreak = regWrite & selBreak;
    wire writeBflag = regWrite & selBflag;

    // Read multiplexer; unmapped addresses read zero
    wire [7:0] breakView = 8'(bexit_q) << `ELS_BIT_BEXIT;
    wire [7:0] bflagView = 8'(break_clear_enable_q) << `ELS_BIT_BREAK_CLEAR_ENABLE;
    wire [7:0] readMux = selBreak ? breakView :
                         selCause ? cause_q :
                         selBflag ? bflagView :
                         selIrqA ? irqViewA :
                         selIrqB ? irqViewB :
                         selIrqC ? irqViewC : 8'h00;

    // Power state decode
    wire inRun = state_q == PWR_RUN;
    wire inWait = state_q == PWR_WAIT;
    wire inStop = state_q == PWR_STOP;
    wire inRecover = state_q == PWR_RECOVER;
    wire anyIrq = |irqReq;
    wire exitEvent = anyIrq | breakReq;
    wire [12:0] recLast = shortSel_q ? ShortLast : LongLast;
    wire recDone = inRecover & xtalTick & (count_q == recLast);
    wire enterLow = inRun & (waitExec | stopExec);

    // Sequencer next state; resets leave any low-power state at once
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            PWR_RUN:
            begin
                if (stopExec & ~anyReset)
                begin
                    state_d = PWR_STOP;
                end
                else if (waitExec & ~anyReset)
                begin
                    state_d = PWR_WAIT;
                end
            end
            PWR_WAIT:
            begin
                if (anyReset | exitEvent)
                begin
                    state_d = PWR_RUN;
                end
            end
            PWR_STOP:
            begin
                if (anyReset)
                begin
                    state_d = PWR_RUN;
                end
                else if (exitEvent)
                begin
                    state_d = PWR_RECOVER;
                end
            end
            PWR_RECOVER:
            begin
                if (anyReset | recDone)
                begin
                    state_d = PWR_RUN;
                end
            end
        endcase
    end

    // Counter cleared through stop, counts crystal ticks in recovery
    assign count_d = (inStop | ~inRecover) ? 13'h0000 :
                     xtalTick ? count_q + 13'h0001 : count_q;
    // Recovery length sensed as recovery begins
    assign shortSel_d = (inStop & exitEvent) ? shortStopRecovery : shortSel_q;

    // Stacking one cycle after an interrupt wakes wait with no break request, or after recovery ends
    assign wakeArb_d = ~anyReset & ((inWait & anyIrq & ~breakReq) | recDone);
    assign clrMask_d = enterLow & ~anyReset;

    // Arbitration at an instruction boundary or after a wake
    wire arbNow = (instrDone & inRun) | wakeArb_q;
    wire takeBreak = arbNow & (brkPend_q | breakReq);
    wire takeIrq = arbNow & anyIrq & ~cpuIMask;

    // Latched request holds until acknowledged; resets cancel it
    always_comb
    begin
        latched_d = latched_q;
        vector_d = vector_q;
        swi_d = swi_q;
        if (anyReset)
        begin
            latched_d = 1'b0;
            vector_d = `ELS_VEC_NONE;
            swi_d = 1'b0;
        end
        else if (latched_q)
        begin
            if (intAck)
            begin
                latched_d = 1'b0;
                vector_d = `ELS_VEC_NONE;
                swi_d = 1'b0;
            end
        end
        else if (takeBreak)
        begin
            latched_d = 1'b1;
            vector_d = `ELS_VEC_SOFT;
            swi_d = 1'b1;
        end
        else if (takeIrq)
        begin
            latched_d = 1'b1;
            vector_d = pickSource(irqReq);
        end
    end

    // Break bookkeeping; a request waits for the next boundary
    assign brkPend_d = ~anyReset & (breakReq | (brkPend_q & ~(takeBreak & ~latched_q)));
    assign brkState_d = ~anyReset & ((takeBreak & ~latched_q) | (brkState_q & ~breakDone));

    // Break exit flag: new event beats a software clear, reset beats both
    assign bexit_d = anyReset ? 1'b0 :
                     ((inWait | inStop) & breakReq) ? 1'b1 :
                     (writeBreak & ~regWdata[`ELS_BIT_BEXIT]) ? 1'b0 : bexit_q;

    assign break_clear_enable_d = writeBflag ? regWdata[`ELS_BIT_BREAK_CLEAR_ENABLE] : break_clear_enable_q;

    // Read clears the causes; a reset arriving with the read still shows
    assign cause_d = (readCause ? 8'h00 : cause_q) | causeSet;

    // Read data stands in the cycle after the strobe only
    assign rdata_d = regRead ? readMux : 8'h00;

    // Pin level synchronisers
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            pinMeta_q <= 1'b1;
            pinSync_q <= 1'b1;
            lineMeta_q <= 1'b0;
            lineSync_q <= 1'b0;
        end
        else
        begin
            pinMeta_q <= pinResetN;
            pinSync_q <= pinMeta_q;
            lineMeta_q <= irqLinePin;
            lineSync_q <= lineMeta_q;
        end
    end

    // Sequencer and counter
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= PWR_RUN;
            count_q <= 13'h0000;
            shortSel_q <= 1'b0;
            wakeArb_q <= 1'b0;
            clrMask_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            count_q <= count_d;
            shortSel_q <= shortSel_d;
            wakeArb_q <= wakeArb_d;
            clrMask_q <= clrMask_d;
        end
    end

    // Exception latch and break state
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            latched_q <= 1'b0;
            vector_q <= `ELS_VEC_NONE;
            swi_q <= 1'b0;
            brkPend_q <= 1'b0;
            brkState_q <= 1'b0;
            intRst_q <= 1'b0;
        end
        else
        begin
            latched_q <= latched_d;
            vector_q <= vector_d;
            swi_q <= swi_d;
            brkPend_q <= brkPend_d;
            brkState_q <= brkState_d;
            intRst_q <= anyReset;
        end
    end

    // Software registers; power-on leaves only the power-on cause
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            cause_q <= `ELS_RST_CAUSE;
            bexit_q <= BreakRst[`ELS_BIT_BEXIT];
            break_clear_enable_q <= BflagRst[`ELS_BIT_BREAK_CLEAR_ENABLE];
            rdata_q <= 8'h00;
        end
        else
        begin
            cause_q <= cause_d;
            bexit_q <= bexit_d;
            break_clear_enable_q <= break_clear_enable_d;
            rdata_q <= rdata_d;
        end
    end

    // Clock gating: CPU only in run, peripherals also in wait
    assign cpuClockEn = inRun;
    assign periphClockEn = inRun | inWait;
    assign busClockEn = inRun | inWait;
    assign crystalClockEn = ~inStop;
    // Watchdog keeps running in wait unless disabled by option
    assign watchdogEnable = ~watchdogDisable & ~inStop & ~inRecover;

    // Gate for other modules' flag clears; no flag is ever restored here,
    // so a clear made in break stays, and a held second step clears later
    assign flagClearAllow = ~brkState_q | break_clear_enable_q;

    assign regRdata = rdata_q;
    assign internalReset = intRst_q;
    assign intReq = latched_q;
    assign vectorId = vector_q;
    assign swiForce = swi_q;
    assign breakState = brkState_q;
    assign clearIMask = clrMask_q;
endmodule : els_unit

//--- els_unit_properties.sv
// Purpose: Port-level checks of the exception and low-power unit
// Assumes: One clock domain, reset asynchronous and active high
// Notes: Clear enable shadowed from bus writes to judge the gate
`include "els_cfg.svh"
`timescale 1ns/1ps
module els_unit_properties (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic [15:0] irqReq,
    input wire logic waitExec,
    input wire logic stopExec,
    input wire logic breakReq,
    input wire logic watchdogDisable,
    input wire logic intReq,
    input wire logic [4:0] vectorId,
    input wire logic swiForce,
    input wire logic breakState,
    input wire logic clearIMask,
    input wire logic cpuClockEn,
    input wire logic periphClockEn,
    input wire logic busClockEn,
    input wire logic crystalClockEn,
    input wire logic watchdogEnable,
    input wire logic flagClearAllow
);
    logic bcfeQ;
    // Expected views of the flag registers, source 1 in the top bit
    wire logic [7:0] viewA = {irqReq[0], irqReq[1], irqReq[2], irqReq[3], irqReq[4], irqReq[5], 2'b00};
    wire logic [7:0] viewC = {6'h00, irqReq[15:14]};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Shadow of the clear enable bit
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            bcfeQ <= 1'b0;
        else if (regWrite && regAddr == `ELS_OFF_BFLAG)
            bcfeQ <= regWdata[`ELS_BIT_BREAK_CLEAR_ENABLE];
    end
    flags_a_a: assert property (regRead && regAddr == `ELS_OFF_IRQA |=> regRdata == $past(viewA))
        else $error("first flag view wrong");
    flags_b_a: assert property (regRead && regAddr == `ELS_OFF_IRQB |=> regRdata == $past(irqReq[13:6]))
        else $error("second flag view wrong");
    flags_c_a: assert property (regRead && regAddr == `ELS_OFF_IRQC |=> regRdata == $past(viewC))
        else $error("third flag view wrong");
    break_vector_a: assert property ($rose(breakState) |-> intReq && swiForce && vectorId == 5'h1f)
        else $error("break did not force soft vector");
    clear_gate_a: assert property (flagClearAllow == (!breakState || bcfeQ))
        else $error("flag clear gate wrong");
    mask_clear_a: assert property (clearIMask |-> !cpuClockEn)
        else $error("mask cleared with cpu clocked");
    wait_clocks_a: assert property (clearIMask && $past(waitExec) |-> periphClockEn && busClockEn && crystalClockEn)
        else $error("wait stopped peripheral clocks");
    stop_clocks_a: assert property (clearIMask && $past(stopExec) |-> !(busClockEn || crystalClockEn || periphClockEn))
        else $error("stop left a clock running");
    wait_wake_a: assert property (!cpuClockEn && busClockEn && irqReq != 16'h0000 |=> cpuClockEn)
        else $error("wait not left on request");
    watchdog_run_a: assert property (periphClockEn |-> watchdogEnable == !watchdogDisable)
        else $error("watchdog enable wrong");
    cover property (swiForce && intReq);
    cover property ($rose(breakState));
    cover property (clearIMask && $past(stopExec));
    cover property (!cpuClockEn && busClockEn && irqReq != 16'h0000);
endmodule : els_unit_properties

bind els_unit els_unit_properties els_unit_properties_i (.*);

//--- testbench.sv
// Purpose: Self-checking bench of the exception and low-power unit
// Assumes: Stop recovery shortened to 64 and 32 crystal ticks
// Notes: Blank vectors and high interrupt line held for monitor entry
`include "els_cfg.svh"
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, cpuIMask = 1'b1, breakReq = 1'b0;
    logic breakDone = 1'b0, waitExec = 1'b0, stopExec = 1'b0, xtalTick = 1'b0, shortStopRecovery = 1'b0;
    logic watchdogDisable = 1'b0, pinResetN = 1'b1, watchdogReset = 1'b0, badOpcodeReset = 1'b0;
    logic badFetchAddr = 1'b0, opcodeFetch = 1'b0, monitorEntry = 1'b0, lowVoltageReset = 1'b0, slowAck = 1'b1;
    logic vectorsBlank = 1'b1, irqLinePin = 1'b1, instrDone, intAck, internalReset, intReq, swiForce;
    logic breakState, clearIMask, cpuClockEn, periphClockEn, busClockEn, crystalClockEn, watchdogEnable;
    logic flagClearAllow;
    logic [15:0] regAddr = 16'h0000, irqReq = 16'h0000;
    logic [7:0] regWdata = 8'h00, regRdata, got;
    logic [4:0] vectorId;
    int n_fail = 0, n_compared = 0;
    els_unit #(.LONG_CYC(64), .SHORT_CYC(32)) els_unit_i (.*);
    els_cpu_model els_cpu_model_i (.ref_clk(ref_clk), .reset(reset), .intReq(intReq), .cpuClockEn(cpuClockEn),
        .slowAck(slowAck), .instrDone(instrDone), .intAck(intAck));
    always #2.5 ref_clk = ~ref_clk;
    task automatic test_done;
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 got = regRdata;
    endtask : rd
    // Bounded wait for a latched exception
    task automatic wait_int;
        for (int i = 0; i < 40 && intReq !== 1'b1; i++)
            @(posedge ref_clk) #1;
    endtask : wait_int
    task automatic t_cause;
        logic [7:0] expTab [7] = '{8'h20, 8'h10, 8'h02, 8'h00, 8'h08, 8'h04, 8'h40};
        rd(`ELS_OFF_CAUSE);
        chk("cause at power-on", 8'h80, got);
        rd(`ELS_OFF_CAUSE);
        chk("cause after read", 8'h00, got);
        for (int k = 0; k < 7; k++)
        begin
            @(posedge ref_clk);
            watchdogReset <= (k == 0);
            badOpcodeReset <= (k == 1);
            lowVoltageReset <= (k == 2);
            badFetchAddr <= (k == 3 || k == 4);
            opcodeFetch <= (k == 4);
            monitorEntry <= (k == 5);
            pinResetN <= (k != 6);
            cyc(3);
            {watchdogReset, badOpcodeReset, lowVoltageReset, badFetchAddr, opcodeFetch, monitorEntry} <= 6'h00;
            pinResetN <= 1'b1;
            #1 chk("internal reset", {7'h00, k != 3}, {7'h00, internalReset});
            cyc(8);
            rd(`ELS_OFF_CAUSE);
            chk("cause source", expTab[k], got);
        end
    endtask : t_cause
    task automatic t_flags(input logic [15:0] pat);
        @(posedge ref_clk);
        irqReq <= pat;
        wr(`ELS_OFF_IRQA, 8'hff);
        rd(`ELS_OFF_IRQA);
        chk("flags a", {pat[0], pat[1], pat[2], pat[3], pat[4], pat[5], 2'b00}, got);
        rd(`ELS_OFF_IRQB);
        chk("flags b", pat[13:6], got);
        rd(`ELS_OFF_IRQC);
        chk("flags c", {6'h00, pat[15:14]}, got);
        rd(16'hfe02);
        chk("unmapped", 8'h00, got);
    endtask : t_flags
    task automatic t_irq;
        @(posedge ref_clk);
        slowAck <= 1'b0;
        irqReq <= 16'h0014;
        cpuIMask <= 1'b0;
        wait_int;
        chk("vector", 8'h03, {3'h0, vectorId});
        @(posedge ref_clk);
        cpuIMask <= 1'b1;
        irqReq <= 16'h0000;
        slowAck <= 1'b1;
        cyc(16);
    endtask : t_irq
    // Interrupt wakes wait; arbitration one cycle after the wake
    task automatic t_wake;
        @(posedge ref_clk);
        slowAck <= 1'b0;
        cpuIMask <= 1'b0;
        watchdogDisable <= 1'b1;
        waitExec <= 1'b1;
        @(posedge ref_clk);
        waitExec <= 1'b0;
        irqReq <= 16'h0100;
        @(posedge ref_clk);
        #1 chk("wake", 8'h01, {6'h00, watchdogEnable, cpuClockEn});
        @(posedge ref_clk);
        #1 chk("wake vector", 8'h89, {intReq, 2'h0, vectorId});
        @(posedge ref_clk);
        cpuIMask <= 1'b1;
        irqReq <= 16'h0000;
        slowAck <= 1'b1;
        watchdogDisable <= 1'b0;
        cyc(16);
    endtask : t_wake
    task automatic t_break;
        wr(`ELS_OFF_BFLAG, 8'h00);
        @(posedge ref_clk);
        waitExec <= 1'b1;
        @(posedge ref_clk);
        waitExec <= 1'b0;
        #1 chk("wait entry", 8'h0b, {4'h0, clearIMask, cpuClockEn, periphClockEn, watchdogEnable});
        @(posedge ref_clk);
        breakReq <= 1'b1;
        @(posedge ref_clk);
        breakReq <= 1'b0;
        wait_int;
        chk("break take", 8'hfe, {vectorId, swiForce, breakState, flagClearAllow});
        rd(`ELS_OFF_BREAK);
        chk("break exit set", 8'h02, got & 8'h02);
        wr(`ELS_OFF_BFLAG, 8'h80);
        #1 chk("clear allowed", 8'h01, {7'h00, flagClearAllow});
        wr(`ELS_OFF_BREAK, 8'h00);
        rd(`ELS_OFF_BREAK);
        chk("break exit cleared", 8'h00, got & 8'h02);
        @(posedge ref_clk);
        breakDone <= 1'b1;
        @(posedge ref_clk);
        breakDone <= 1'b0;
        cyc(14);
        chk("break left", 8'h00, {6'h00, breakState, intReq});
    endtask : t_break
    task automatic tick;
        @(posedge ref_clk);
        xtalTick <= 1'b1;
        @(posedge ref_clk);
        xtalTick <= 1'b0;
    endtask : tick
    task automatic t_stop(input logic sh);
        @(posedge ref_clk);
        shortStopRecovery <= sh;
        stopExec <= 1'b1;
        @(posedge ref_clk);
        stopExec <= 1'b0;
        #1 chk("stop entry", 8'h01, {4'h0, crystalClockEn, busClockEn, periphClockEn, clearIMask});
        cyc(4);
        // Short recovery leaves stop on a request, long recovery on a break
        irqReq <= sh ? 16'h0002 : 16'h0000;
        breakReq <= !sh;
        cyc(3);
        irqReq <= 16'h0000;
        breakReq <= 1'b0;
        repeat ((sh ? 32 : 64) - 1) tick;
        cyc(2);
        #1 chk("recovery early", 8'h00, {7'h00, cpuClockEn});
        tick;
        cyc(2);
        #1 chk("recovery done", 8'h01, {7'h00, cpuClockEn});
        rd(`ELS_OFF_BREAK);
        chk("stop exit flag", sh ? 8'h00 : 8'h02, got & 8'h02);
    endtask : t_stop
    // Watchdog against a hung handshake
    initial
    begin
        cyc(20000);
        n_fail++;
        test_done;
    end
    initial
    begin
        cyc(2);
        reset <= 1'b0;
        t_cause;
        t_flags(16'h8421);
        t_flags(16'h7bde);
        t_irq;
        t_wake;
        t_break;
        t_stop(1'b1);
        t_stop(1'b0);
        test_done;
    end
endmodule : testbench
